// ==== rtl/spi_flash_pkg.sv ====
// constants, field layouts and state codes for the flash read and watermark block
`default_nettype none

package spi_flash_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [6:0] OFF_TXMARK = 7'h50;
	localparam logic [6:0] OFF_RXMARK = 7'h54;
	localparam logic [6:0] OFF_FLASH_CTRL = 7'h60;
	localparam logic [6:0] OFF_READ_FMT = 7'h64;
	localparam logic [6:0] OFF_INT_EN = 7'h70;
	localparam logic [6:0] OFF_PENDING = 7'h74;

	// ------------------------------------------------------------
	// lane width codes
	// ------------------------------------------------------------
	localparam logic [1:0] PROTO_SINGLE = 2'h0;
	localparam logic [1:0] PROTO_DUAL = 2'h1;
	localparam logic [1:0] PROTO_QUAD = 2'h2;

	// ------------------------------------------------------------
	// read format layout and reset values
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] pad_code;
		logic [7:0] cmd_code;
		logic [1:0] rsvd;
		logic [1:0] data_proto;
		logic [1:0] addr_proto;
		logic [1:0] cmd_proto;
		logic [3:0] pad_cnt;
		logic [2:0] addr_len;
		logic cmd_en;
	} read_fmt_t;

	localparam read_fmt_t READ_FMT_RST = '{pad_code: 8'h00, cmd_code: 8'h03, rsvd: 2'h0,
		data_proto: 2'h0, addr_proto: 2'h0, cmd_proto: 2'h0, pad_cnt: 4'h0,
		addr_len: 3'h3, cmd_en: 1'h1};
	localparam logic [31:0] READ_FMT_WMASK = 32'hffff_3fff;
	localparam logic FLASH_CTRL_RST = 1'h1;
	localparam logic [1:0] INT_EN_RST = 2'h0;
	localparam logic [1:0] PEND_RST = 2'h0;
	localparam logic [2:0] RXMARK_RST = 3'h0;
	localparam logic [2:0] TXMARK_RST_FLASH = 3'h1;
	localparam logic [2:0] TXMARK_RST_PLAIN = 3'h0;
	localparam int BIT_TXWM = 0;
	localparam int BIT_RXWM = 1;
	localparam logic [2:0] MAX_ADDR_BYTES = 3'h4;
	localparam logic [3:0] PAD_PATTERN_BITS = 4'h8;

	// ------------------------------------------------------------
	// timing: serial clock half period
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCK_HALF_NS = 40;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// sequencer states, gray along the read path
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD = 3'h1,
		ST_ADDR = 3'h3,
		ST_PAD = 3'h2,
		ST_DATA = 3'h6,
		ST_DONE = 3'h7
	} seq_state_t;

endpackage

`default_nettype wire

// ==== rtl/spi_flash_watermark.sv ====
// watermark pending/enable registers and memory-mapped serial flash read sequencer
//
// Chosen here: the strobed register port.
`default_nettype none

// What this block does
// [R1] enable register is read/write and clears to zero at reset
// [R2] pending register is read only; writes leave it untouched
// [R3] transmit pending set while transmit occupancy below transmit mark
// [R4] transmit pending drops once occupancy reaches the transmit mark
// [R5] receive pending set while receive occupancy above receive mark
// [R6] receive pending drops once occupancy falls to the receive mark
// [R7] enable bit 0 is transmit, bit 1 receive, upper bits reserved
// [R8] pending bit 0 transmit, bit 1 receive, both zero after reset
// [R9] flash mode bit 0 of flash control, set after reset
// [R10] each mapped access in flash mode runs a whole flash read in hardware; outside it the access is refused with an error
// [R11] read order: opcode, address bytes, dummy cycles, data bytes
// [R12] format bit 0 enables opcode byte, resets to one
// [R13] format bits 3:1 give address byte count 0..4, reset three
// [R14] format bits 7:4 give dummy cycle count, reset zero
// [R15] format bits 9:8 give opcode lane width, reset single
// [R16] format bits 11:10 give address and dummy lane width
// [R17] format bits 13:12 give data receive lane width
// [R18] format bits 23:16 hold opcode value, reset 0x03
// [R19] bits 31:24 driven until eight pattern bits are out: eight dummy bit times single, four dual, two quad
// [R20] width codes single, dual, quad; unused data lines left undriven
// [R21] transmit mark three bits, reset one when flash capable
// [R22] receive mark three bits, reset zero
// [R23] interrupt output high when any enabled pending bit is set
module spi_flash_watermark #(
	parameter bit FLASH_CAPABLE = 1'b1,
	parameter int LEVEL_W = 4,
	parameter int SCK_HALF = spi_flash_pkg::SCK_HALF_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [6:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	input wire logic [LEVEL_W-1:0] tx_level,
	input wire logic [LEVEL_W-1:0] rx_level,
	output logic [2:0] tx_mark_q,
	output logic [2:0] rx_mark_q,
	output logic irq_q,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ready_q,
	output logic mem_err_q,
	output logic [31:0] mem_rdata_q,
	output logic sck_q,
	output logic cs_b_q,
	output logic [3:0] dq_o_q,
	output logic [3:0] dq_oe_b_q,
	input wire logic [3:0] dq_i
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic fen_q;
	spi_flash_pkg::read_fmt_t rd_fmt_q;
	spi_flash_pkg::read_fmt_t fmt_l_q;
	logic [1:0] int_en_q;
	logic [1:0] pend_q;
	logic [3:0] dq_s1_q;
	logic [3:0] dq_s2_q;
	logic [3:0] dq_s3_q;
	logic [3:0] dq_in_q;
	logic [7:0] div_q;
	logic tick;
	spi_flash_pkg::seq_state_t state_q;
	logic [31:0] sh_q;
	logic [31:0] rx_q;
	logic [5:0] cyc_q;
	logic [3:0] pad_left_q;
	logic [1:0] cur_log;
	logic [2:0] step;
	logic take;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// log2 of lanes per bit time; the unused code 3 falls back to single
	function automatic logic [1:0] lane_log(input logic [1:0] p);
		lane_log = (p == spi_flash_pkg::PROTO_QUAD) ? 2'h2 :
			(p == spi_flash_pkg::PROTO_DUAL) ? 2'h1 : 2'h0; // R20
	endfunction

	// counts above four are clamped so the shifter never runs dry
	function automatic logic [2:0] addr_bytes(input spi_flash_pkg::read_fmt_t f);
		addr_bytes = (f.addr_len > spi_flash_pkg::MAX_ADDR_BYTES) ?
			spi_flash_pkg::MAX_ADDR_BYTES : f.addr_len; // R13
	endfunction

	// phase that follows, skipping any phase of zero length
	function automatic spi_flash_pkg::seq_state_t next_phase(
		input spi_flash_pkg::seq_state_t from, input spi_flash_pkg::read_fmt_t f);
		next_phase = spi_flash_pkg::ST_DATA;
		if (from != spi_flash_pkg::ST_PAD && f.pad_cnt != 4'h0) begin
			next_phase = spi_flash_pkg::ST_PAD; // R14
		end
		if ((from == spi_flash_pkg::ST_IDLE || from == spi_flash_pkg::ST_CMD)
			&& f.addr_len != 3'h0) begin
			next_phase = spi_flash_pkg::ST_ADDR; // R11
		end
		if (from == spi_flash_pkg::ST_IDLE && f.cmd_en) begin
			next_phase = spi_flash_pkg::ST_CMD; // R12
		end
	endfunction

	// bit times in a phase at its lane width
	function automatic logic [5:0] phase_cycles(input spi_flash_pkg::seq_state_t s,
		input spi_flash_pkg::read_fmt_t f);
		phase_cycles = 6'h20 >> lane_log(f.data_proto); // R17
		if (s == spi_flash_pkg::ST_CMD) begin
			phase_cycles = 6'h08 >> lane_log(f.cmd_proto); // R15
		end
		if (s == spi_flash_pkg::ST_ADDR) begin
			phase_cycles = {addr_bytes(f), 3'h0} >> lane_log(f.addr_proto); // R16
		end
		if (s == spi_flash_pkg::ST_PAD) begin
			phase_cycles = {2'h0, f.pad_cnt}; // R14
		end
	endfunction

	// shifter contents on entry to a phase, msb leaves first
	function automatic logic [31:0] phase_load(input spi_flash_pkg::seq_state_t s,
		input spi_flash_pkg::read_fmt_t f, input logic [31:0] a);
		phase_load = 32'h0;
		if (s == spi_flash_pkg::ST_CMD) begin
			phase_load = {f.cmd_code, 24'h0}; // R18
		end
		if (s == spi_flash_pkg::ST_ADDR) begin
			phase_load = a << {3'h4 - addr_bytes(f), 3'h0}; // R13
		end
		if (s == spi_flash_pkg::ST_PAD) begin
			phase_load = {f.pad_code, 24'h0}; // R19
		end
	endfunction

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// writes to the pending offset fall to the default and change nothing
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_mark_q <= FLASH_CAPABLE ? spi_flash_pkg::TXMARK_RST_FLASH :
				spi_flash_pkg::TXMARK_RST_PLAIN; // R21
			rx_mark_q <= spi_flash_pkg::RXMARK_RST; // R22
			fen_q <= spi_flash_pkg::FLASH_CTRL_RST; // R9
			rd_fmt_q <= spi_flash_pkg::READ_FMT_RST; // R12
			int_en_q <= spi_flash_pkg::INT_EN_RST; // R1
		end else if (reg_wr) begin
			case (reg_addr)
				spi_flash_pkg::OFF_TXMARK: tx_mark_q <= reg_wdata[2:0]; // R21
				spi_flash_pkg::OFF_RXMARK: rx_mark_q <= reg_wdata[2:0]; // R22
				spi_flash_pkg::OFF_FLASH_CTRL: fen_q <= reg_wdata[0]; // R9
				spi_flash_pkg::OFF_READ_FMT: begin
					rd_fmt_q <= spi_flash_pkg::read_fmt_t'(reg_wdata & spi_flash_pkg::READ_FMT_WMASK);
				end
				spi_flash_pkg::OFF_INT_EN: int_en_q <= reg_wdata[1:0]; // R7
				default: ; // R2
			endcase
		end
	end

	// ------------------------------------------------------------
	// register reads, data valid only in the cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata_q <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				spi_flash_pkg::OFF_TXMARK: reg_rdata_q <= {29'h0, tx_mark_q};
				spi_flash_pkg::OFF_RXMARK: reg_rdata_q <= {29'h0, rx_mark_q};
				spi_flash_pkg::OFF_FLASH_CTRL: reg_rdata_q <= {31'h0, fen_q};
				spi_flash_pkg::OFF_READ_FMT: reg_rdata_q <= rd_fmt_q;
				spi_flash_pkg::OFF_INT_EN: reg_rdata_q <= {30'h0, int_en_q}; // R7
				spi_flash_pkg::OFF_PENDING: reg_rdata_q <= {30'h0, pend_q}; // R8
				default: reg_rdata_q <= 32'h0;
			endcase
		end else begin
			reg_rdata_q <= 32'h0;
		end
	end

	// ------------------------------------------------------------
	// watermark conditions and interrupt line
	// ------------------------------------------------------------
	// pending follows the levels, so it clears itself with no software write
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend_q <= spi_flash_pkg::PEND_RST; // R8
		end else begin
			pend_q[spi_flash_pkg::BIT_TXWM] <= tx_level < LEVEL_W'(tx_mark_q); // R3 R4
			pend_q[spi_flash_pkg::BIT_RXWM] <= rx_level > LEVEL_W'(rx_mark_q); // R5 R6
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(pend_q & int_en_q); // R23
		end
	end

	// ------------------------------------------------------------
	// data line synchroniser: a bit changes once stages two and three agree
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dq_s1_q <= 4'h0;
			dq_s2_q <= 4'h0;
			dq_s3_q <= 4'h0;
			dq_in_q <= 4'h0;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
			dq_s3_q <= dq_s2_q;
			dq_in_q <= (dq_s2_q & ~(dq_s2_q ^ dq_s3_q)) | (dq_in_q & (dq_s2_q ^ dq_s3_q));
		end
	end

	// ------------------------------------------------------------
	// serial clock divider, runs only while a read is under way
	// ------------------------------------------------------------
	assign tick = (div_q == 8'(SCK_HALF - 1));
	assign take = (state_q == spi_flash_pkg::ST_IDLE) && mem_req && !mem_ready_q;

	always_ff @(posedge clk) begin
		if (!rst_b || state_q == spi_flash_pkg::ST_IDLE || state_q == spi_flash_pkg::ST_DONE) begin
			div_q <= 8'h0;
		end else begin
			div_q <= tick ? 8'h0 : div_q + 8'h1;
		end
	end

	// lane width of the phase in flight
	always_comb begin
		unique case (state_q)
			spi_flash_pkg::ST_CMD: cur_log = lane_log(fmt_l_q.cmd_proto); // R15
			spi_flash_pkg::ST_ADDR, spi_flash_pkg::ST_PAD: begin
				cur_log = lane_log(fmt_l_q.addr_proto); // R16
			end
			default: cur_log = lane_log(fmt_l_q.data_proto); // R17
		endcase
		step = 3'h1 << cur_log;
	end

	// ------------------------------------------------------------
	// read sequencer: mode 0, shift on falling edge, sample on rising
	// ------------------------------------------------------------
	// the format is latched at start so a mid-read write cannot tear a frame
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= spi_flash_pkg::ST_IDLE;
			fmt_l_q <= spi_flash_pkg::READ_FMT_RST;
			sh_q <= 32'h0;
			rx_q <= 32'h0;
			cyc_q <= 6'h0;
			pad_left_q <= 4'h0;
			sck_q <= 1'b0;
			cs_b_q <= 1'b1;
			mem_ready_q <= 1'b0;
			mem_err_q <= 1'b0;
			mem_rdata_q <= 32'h0;
		end else begin
			mem_ready_q <= 1'b0;
			mem_err_q <= 1'b0;
			unique case (state_q)
				spi_flash_pkg::ST_IDLE: begin
					if (take && !fen_q) begin
						mem_ready_q <= 1'b1; // R9
						mem_err_q <= 1'b1;
					end else if (take) begin
						state_q <= next_phase(spi_flash_pkg::ST_IDLE, rd_fmt_q); // R10
						fmt_l_q <= rd_fmt_q;
						sh_q <= phase_load(next_phase(spi_flash_pkg::ST_IDLE, rd_fmt_q),
							rd_fmt_q, mem_addr);
						cyc_q <= phase_cycles(next_phase(spi_flash_pkg::ST_IDLE, rd_fmt_q),
							rd_fmt_q);
						pad_left_q <= spi_flash_pkg::PAD_PATTERN_BITS;
						cs_b_q <= 1'b0;
						rx_q <= 32'h0;
					end
				end
				spi_flash_pkg::ST_CMD, spi_flash_pkg::ST_ADDR, spi_flash_pkg::ST_PAD,
				spi_flash_pkg::ST_DATA: begin
					if (tick && !sck_q) begin
						sck_q <= 1'b1;
						if (state_q == spi_flash_pkg::ST_DATA) begin
							unique case (cur_log)
								2'h0: rx_q <= {rx_q[30:0], dq_in_q[1]};
								2'h1: rx_q <= {rx_q[29:0], dq_in_q[1:0]};
								default: rx_q <= {rx_q[27:0], dq_in_q};
							endcase
						end
					end else if (tick) begin
						sck_q <= 1'b0;
						sh_q <= sh_q << step;
						cyc_q <= cyc_q - 6'h1;
						if (state_q == spi_flash_pkg::ST_PAD) begin
							pad_left_q <= (pad_left_q > {1'b0, step}) ?
								pad_left_q - {1'b0, step} : 4'h0; // R19
						end
						if (cyc_q == 6'h1 && state_q == spi_flash_pkg::ST_DATA) begin
							state_q <= spi_flash_pkg::ST_DONE;
						end else if (cyc_q == 6'h1) begin
							state_q <= next_phase(state_q, fmt_l_q); // R11
							sh_q <= phase_load(next_phase(state_q, fmt_l_q), fmt_l_q, mem_addr);
							cyc_q <= phase_cycles(next_phase(state_q, fmt_l_q), fmt_l_q);
						end
					end
				end
				spi_flash_pkg::ST_DONE: begin
					// first flash byte lands in the low byte of the word
					state_q <= spi_flash_pkg::ST_IDLE;
					cs_b_q <= 1'b1;
					mem_ready_q <= 1'b1;
					mem_rdata_q <= {rx_q[7:0], rx_q[15:8], rx_q[23:16], rx_q[31:24]};
				end
				default: begin
					state_q <= spi_flash_pkg::ST_IDLE;
					cs_b_q <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// data line drive, one cycle behind the shifter
	// ------------------------------------------------------------
	// lines not used by the width, receive phases and idle are released
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dq_o_q <= 4'h0;
			dq_oe_b_q <= 4'hf;
		end else if (state_q == spi_flash_pkg::ST_IDLE || state_q == spi_flash_pkg::ST_DONE ||
			state_q == spi_flash_pkg::ST_DATA ||
			(state_q == spi_flash_pkg::ST_PAD && pad_left_q == 4'h0)) begin
			dq_o_q <= 4'h0;
			dq_oe_b_q <= 4'hf; // R20
		end else begin
			unique case (cur_log)
				2'h0: begin
					dq_o_q <= {3'h0, sh_q[31]};
					dq_oe_b_q <= 4'he; // R20
				end
				2'h1: begin
					dq_o_q <= {2'h0, sh_q[31:30]};
					dq_oe_b_q <= 4'hc;
				end
				default: begin
					dq_o_q <= sh_q[31:28];
					dq_oe_b_q <= 4'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_take;
		take && fen_q;
	endsequence

	sequence s_cmd_left;
		state_q == spi_flash_pkg::ST_CMD ##1 state_q != spi_flash_pkg::ST_CMD;
	endsequence

	property p_en_rst;
		$rose(rst_b) |-> int_en_q == 2'h0 && pend_q == 2'h0;
	endproperty
	a_en_rst: assert property (p_en_rst) else $error("enable or pending not clear"); // R1

	property p_fmt_rst;
		$rose(rst_b) |-> rd_fmt_q == spi_flash_pkg::READ_FMT_RST && fen_q;
	endproperty
	a_fmt_rst: assert property (p_fmt_rst) else $error("format or mode reset wrong"); // R12

	property p_tx_pend;
		$past(rst_b) |-> pend_q[0] == ($past(tx_level) < LEVEL_W'($past(tx_mark_q)));
	endproperty
	a_tx_pend: assert property (p_tx_pend) else $error("transmit pending wrong"); // R3

	property p_rx_pend;
		$past(rst_b) |-> pend_q[1] == ($past(rx_level) > LEVEL_W'($past(rx_mark_q)));
	endproperty
	a_rx_pend: assert property (p_rx_pend) else $error("receive pending wrong"); // R5

	property p_pend_read;
		reg_rd && reg_addr == spi_flash_pkg::OFF_PENDING |=> reg_rdata_q == {30'h0, $past(pend_q)};
	endproperty
	a_pend_read: assert property (p_pend_read) else $error("pending read wrong"); // R8

	property p_irq;
		$past(rst_b) |-> irq_q == |($past(pend_q) & $past(int_en_q));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt line wrong"); // R23

	property p_start;
		s_take |=> state_q != spi_flash_pkg::ST_IDLE && !cs_b_q;
	endproperty
	a_start: assert property (p_start) else $error("read not started"); // R10

	property p_order;
		s_cmd_left |-> state_q inside {spi_flash_pkg::ST_ADDR, spi_flash_pkg::ST_PAD,
			spi_flash_pkg::ST_DATA};
	endproperty
	a_order: assert property (p_order) else $error("phase order wrong"); // R11

	property p_err;
		take && !fen_q |=> mem_ready_q && mem_err_q && state_q == spi_flash_pkg::ST_IDLE;
	endproperty
	a_err: assert property (p_err) else $error("access outside flash mode not refused"); // R9

	property p_idle_float;
		state_q == spi_flash_pkg::ST_IDLE ##1 state_q == spi_flash_pkg::ST_IDLE |->
			dq_oe_b_q == 4'hf;
	endproperty
	a_idle_float: assert property (p_idle_float) else $error("idle lines driven"); // R20

	property p_cmd_single;
		state_q == spi_flash_pkg::ST_CMD ##1 state_q == spi_flash_pkg::ST_CMD &&
			fmt_l_q.cmd_proto == spi_flash_pkg::PROTO_SINGLE |-> dq_oe_b_q == 4'he;
	endproperty
	a_cmd_single: assert property (p_cmd_single) else $error("opcode lanes wrong"); // R15

	property p_done;
		state_q == spi_flash_pkg::ST_DONE |=> mem_ready_q && !mem_err_q && cs_b_q;
	endproperty
	a_done: assert property (p_done) else $error("read not completed"); // R10

endmodule

`default_nettype wire

// ==== bench/flash_model.sv ====
// behavioural serial flash answering mapped reads on one, two or four data lines
`default_nettype none

module flash_model (
	input wire logic clk,
	input wire logic sck,
	input wire logic cs_b,
	input wire logic [3:0] dq_o,
	input wire logic [3:0] dq_oe_b,
	input wire logic [1:0] proto,
	input wire logic [6:0] skip,
	input wire logic [31:0] word,
	output logic [3:0] dq_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// header capture and data drive
	// ------------------------------------------------------------
	logic [6:0] rises = 7'h0;
	logic [3:0] seen [0:63];
	logic [3:0] drv = 4'h0;
	logic [3:0] val = 4'h0;
	logic [3:0] junk = 4'h5;
	logic [31:0] s;
	logic [31:0] t;
	int w;
	assign s = {word[7:0], word[15:8], word[23:16], word[31:24]};
	// lanes seen at each rise; frame end lets go of every line
	always @(posedge sck or posedge cs_b) begin
		if (cs_b) begin
			rises <= 7'h0;
			drv <= 4'h0;
		end else begin
			seen[rises[5:0]] <= dq_o;
			rises <= rises + 7'h1;
		end
	end
	// data only after the header bit times, first byte first
	always @(negedge sck or negedge cs_b) begin
		if (!cs_b && rises >= skip) begin
			w = (proto == 2'h2) ? 4 : (proto == 2'h1) ? 2 : 1;
			t = s << (w * (int'(rises) - int'(skip)));
			case (proto)
				2'h1: begin
					drv <= 4'h3;
					val <= {2'h0, t[31:30]};
				end
				2'h2: begin
					drv <= 4'hf;
					val <= t[31:28];
				end
				default: begin
					drv <= 4'h2;
					val <= {2'h0, t[31], 1'h0};
				end
			endcase
		end
	end
	// floating lines wander so a stale bit never looks valid
	always @(posedge clk) junk <= ~junk;
	assign dq_i = (~dq_oe_b & dq_o) | (dq_oe_b & drv & val) | (dq_oe_b & ~drv & junk);
endmodule

`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the watermark registers and flash read sequencer
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [6:0] reg_addr = 7'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [3:0] tx_level = 4'h4;
	logic [3:0] rx_level = 4'h0;
	logic mem_req = 1'h0;
	logic [31:0] mem_addr = 32'h0;
	logic [31:0] reg_rdata_q;
	logic [31:0] mem_rdata_q;
	logic [2:0] tx_mark_q;
	logic [2:0] rx_mark_q;
	logic irq_q, mem_ready_q, mem_err_q, sck_q, cs_b_q;
	logic [3:0] dq_o_q, dq_oe_b_q, dq_i;
	logic [1:0] fm_proto = 2'h0;
	logic [6:0] fm_skip = 7'h0;
	logic [31:0] fm_word = 32'h0;
	logic [31:0] r;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;

	// ------------------------------------------------------------
	// design, flash and clock
	// ------------------------------------------------------------
	// half period 8 gives the 160 ns serial bit time
	spi_flash_watermark #(.SCK_HALF(8)) DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.tx_level(tx_level), .rx_level(rx_level), .tx_mark_q(tx_mark_q),
		.rx_mark_q(rx_mark_q), .irq_q(irq_q), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ready_q(mem_ready_q), .mem_err_q(mem_err_q), .mem_rdata_q(mem_rdata_q),
		.sck_q(sck_q), .cs_b_q(cs_b_q), .dq_o_q(dq_o_q), .dq_oe_b_q(dq_oe_b_q), .dq_i(dq_i));
	flash_model fm (.clk(clk), .sck(sck_q), .cs_b(cs_b_q), .dq_o(dq_o_q),
		.dq_oe_b(dq_oe_b_q), .proto(fm_proto), .skip(fm_skip), .word(fm_word), .dq_i(dq_i));
	always #5 clk = ~clk;
	// hang guard, well above four flash reads
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			results();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [6:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata_q, e);
	endtask
	// lanes of captured bit times packed msb first
	function automatic logic [31:0] got(int first, int n, int w);
		logic [31:0] v;
		v = 32'h0;
		for (int i = first; i < first + n; i++) v = (v << w) | 32'(fm.seen[i] & 4'((1 << w) - 1));
		return v;
	endfunction
	task automatic frd(input logic [31:0] a, input logic [1:0] p, input logic [6:0] k,
		input logic [31:0] w, input logic e);
		int n;
		@(posedge clk);
		fm_proto <= p;
		fm_skip <= k;
		fm_word <= w;
		mem_req <= 1'h1;
		mem_addr <= a;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (mem_ready_q !== 1'h1 && n < 3000);
		chk({31'h0, mem_ready_q}, 32'h1);
		chk({31'h0, mem_err_q}, {31'h0, e});
		if (!e) chk(mem_rdata_q, w);
		chk({28'h0, dq_oe_b_q}, 32'hf);
		@(posedge clk);
		mem_req <= 1'h0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rc(7'h60, 32'h1);
		rc(7'h64, 32'h0003_0007);
		rc(7'h70, 32'h0);
		rc(7'h74, 32'h0);
		chk({29'h0, tx_mark_q}, 32'h1);
		chk({29'h0, rx_mark_q}, 32'h0);
	endtask
	task automatic t_regs();
		wr(7'h70, 32'hffff_ffff);
		rc(7'h70, 32'h3);
		wr(7'h74, 32'hffff_ffff);
		rc(7'h74, 32'h0);
		wr(7'h64, 32'hffff_ffff);
		rc(7'h64, 32'hffff_3fff);
		wr(7'h64, 32'h0003_0007);
		wr(7'h70, 32'h1);
	endtask
	// tx rises past its mark while rx falls below its mark; rx stays masked
	task automatic t_marks();
		logic [1:0] e;
		wr(7'h50, 32'h3);
		wr(7'h54, 32'h2);
		chk({29'h0, tx_mark_q}, 32'h3);
		for (int lv = 0; lv < 8; lv++) begin
			@(posedge clk);
			tx_level <= 4'(lv);
			rx_level <= 4'(7 - lv);
			e = {(7 - lv) > 2, lv < 3};
			repeat (3) @(posedge clk);
			#1;
			chk({31'h0, irq_q}, {31'h0, e[0]});
			rc(7'h74, {30'h0, e});
		end
	endtask
	task automatic t_single();
		frd(32'h0012_3456, 2'h0, 7'h20, 32'ha1b2_c3d4, 1'h0);
		chk(got(0, 8, 1), 32'h3);
		chk(got(8, 24, 1), 32'h0012_3456);
	endtask
	task automatic t_quad();
		wr(7'h64, 32'h5abb_2828);
		frd(32'h89ab_cdef, 2'h2, 7'h0a, 32'h1357_9bdf, 1'h0);
		chk(got(0, 8, 4), 32'h89ab_cdef);
		chk(got(8, 2, 4), 32'h5a);
	endtask
	task automatic t_dual();
		wr(7'h64, 32'h006b_1503);
		frd(32'h0000_00c5, 2'h1, 7'h08, 32'hc0de_f00d, 1'h0);
		chk(got(0, 4, 2), 32'h6b);
		chk(got(4, 4, 2), 32'hc5);
	endtask
	task automatic t_off();
		wr(7'h60, 32'h0);
		rc(7'h60, 32'h0);
		frd(32'h0000_0010, 2'h0, 7'h0, 32'h0, 1'h1);
		wr(7'h60, 32'h1);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		t_reset();
		t_regs();
		t_marks();
		t_single();
		t_quad();
		t_dual();
		t_off();
		results();
	end
endmodule

`default_nettype wire
